// file: shared/pid_pkg.sv
// Constants, types and register map of the PI controller and display scaling block
// Summary of operation
// - Display value is source times a factor 0.000..16.000, reset default 0.000.
// - Display source 0 scales output frequency, or motor RPM when speed units nonzero.
// - Display source 1 scales motor current in amperes.
// - Display source 2 scales analog input two, held as 0..100.0 percent.
// - Display source 3 scales the selected PI feedback, 0..100.0 percent.
// - Proportional gain 0.0..30.0, default 1.0; more gain, bigger output change.
// - Integral time 0.0..30.0 s, default 1.0; longer time damps response.
// - Mode 0 direct: feedback below setpoint raises speed demand.
// - Mode 1 inverse: falling feedback lowers speed demand.
// - Modes 2 and 3 as 0 and 1, output forced 100% on standby wake.
// - Setpoint source 0 uses stored preset 0.0..100.0 percent, default 0.0.
// - Setpoint source 1 uses analog input one, also readable as status.
// - Setpoint source 2 uses fieldbus process data word two (holding register 3).
// - Feedback source 0 uses analog input two.
// - Feedback source 1 uses analog input one.
// - Feedback source 2 is motor current as percent of rated current.
// - Feedback source 3 is DC bus voltage, 0..1000 V to 0..100 percent.
// - Feedback source 4 is analog one minus analog two, floored at zero.
// - Feedback source 5 is the larger analog input.
// - Standby persists until PI error exceeds wake level 0.0..100.0, default 5.0.
package pid_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] REG_DISP_FACTOR = 8'h00;
    localparam logic [7:0] REG_DISP_SRC = 8'h04;
    localparam logic [7:0] REG_PGAIN = 8'h08;
    localparam logic [7:0] REG_ITIME = 8'h0c;
    localparam logic [7:0] REG_PMODE = 8'h10;
    localparam logic [7:0] REG_SP_SRC = 8'h14;
    localparam logic [7:0] REG_PRESET = 8'h18;
    localparam logic [7:0] REG_FB_SRC = 8'h1c;
    localparam logic [7:0] REG_WAKE = 8'h20;
    localparam logic [7:0] REG_SPEED_UNIT = 8'h24;
    localparam logic [7:0] REG_RATED_I = 8'h28;
    localparam logic [7:0] REG_AN1_STAT = 8'h2c;
    localparam logic [7:0] REG_AN2_STAT = 8'h30;
    localparam logic [7:0] REG_FB_STAT = 8'h34;
    localparam logic [7:0] REG_OUT_STAT = 8'h38;
    localparam logic [7:0] REG_DISP_STAT = 8'h3c;
    localparam logic [7:0] REG_STBY_STAT = 8'h40;
    // Field widths and limits (percent in 0.1 steps, factor in 0.001, gain/time in 0.1)
    localparam int PCT_W = 10;
    localparam logic [9:0] PCT_FULL = 10'h3e8;
    localparam logic [14:0] FACTOR_MAX = 15'h3e80;
    localparam logic [8:0] GAIN_MAX = 9'h12c;
    localparam logic [8:0] TIME_MAX = 9'h12c;
    // Reset values
    localparam logic [14:0] FACTOR_RST = 15'h0000;
    localparam logic [8:0] GAIN_RST = 9'h00a;
    localparam logic [8:0] TIME_RST = 9'h00a;
    localparam logic [9:0] PRESET_RST = 10'h000;
    localparam logic [9:0] WAKE_RST = 10'h032;
    // DC bus: 0..1000 V in volts maps to 0..1000 tenths percent
    localparam logic [9:0] VBUS_FULL = 10'h3e8;
    // Control sample period 10 ms at 10 MHz
    localparam int CLK_HZ = 10_000_000;
    localparam int SAMPLE_US = 10_000;
    localparam int SAMPLE_CYC = CLK_HZ / 1_000_000 * SAMPLE_US;
    // Samples per 0.1 s of integral time
    localparam int TENTH_SAMPLES = 10;

    typedef enum logic [3:0] {
        PID_IDLE = 4'b0001,
        PID_FETCH = 4'b0010,
        PID_CALC = 4'b0100,
        PID_WAKE = 4'b1000
    } pid_state_e;

    typedef struct packed {
        logic [9:0] an1;
        logic [9:0] an2;
        logic [15:0] motor_amps;
        logic [9:0] vbus;
        logic [15:0] out_freq;
        logic [15:0] motor_rpm;
    } pid_meas_s;
endpackage

// file: logic/pid_ctrl.sv
// PI process controller with setpoint/feedback selection and display scaling
`timescale 1ns/10ps
module pid_ctrl #(
    parameter int SAMPLE_CYCLES = pid_pkg::SAMPLE_CYC
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Measurements and fieldbus
    input wire pid_pkg::pid_meas_s meas_i,
    input wire logic [9:0] bus_setpoint_i,
    // Standby
    input wire logic standby_en_i,
    input wire logic standby_i,
    // Results
    output logic [9:0] pi_out_o,
    output logic wake_o,
    output logic [31:0] display_o
);
    import pid_pkg::*;

    // Configuration registers
    logic [14:0] disp_factor;
    logic [1:0] disp_src;
    logic [8:0] pgain;
    logic [8:0] itime;
    logic [1:0] pmode;
    logic [1:0] sp_src;
    logic [9:0] preset;
    logic [2:0] fb_src;
    logic [9:0] wake_lvl;
    logic [7:0] speed_unit;
    logic [15:0] rated_i;

    // Synchronised inputs and sample enable
    pid_meas_s meas_q1;
    pid_meas_s meas;
    logic [9:0] bus_sp_q1;
    logic [9:0] bus_sp;
    logic [1:0] stby_q1;
    logic [1:0] stby;
    logic [31:0] tick_cnt;
    logic tick;

    // Controller state
    pid_state_e state;
    logic [9:0] fb;
    logic [9:0] sp;
    logic signed [11:0] err;
    logic signed [31:0] integ;
    logic stby_prev;
    logic in_stby;
    logic wake_now;

    // Combinational results
    logic [9:0] next_fb;
    logic [9:0] next_sp;
    logic [25:0] cur_pct;
    logic signed [31:0] next_integ;
    logic signed [31:0] pterm;
    logic signed [31:0] iterm;
    logic signed [31:0] sum;
    logic [15:0] disp_base;

    // Register writes
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            disp_factor <= FACTOR_RST;
            disp_src <= 2'h0;
            pgain <= GAIN_RST;
            itime <= TIME_RST;
            pmode <= 2'h0;
            sp_src <= 2'h0;
            preset <= PRESET_RST;
            fb_src <= 3'h0;
            wake_lvl <= WAKE_RST;
            speed_unit <= 8'h00;
            rated_i <= 16'h0001;
        end else if (wr_i) begin
            case (addr_i)
                REG_DISP_FACTOR: disp_factor <= (wdata_i[14:0] > FACTOR_MAX) ?
                    FACTOR_MAX : wdata_i[14:0];
                REG_DISP_SRC: disp_src <= wdata_i[1:0];
                REG_PGAIN: pgain <= (wdata_i[8:0] > GAIN_MAX) ? GAIN_MAX : wdata_i[8:0];
                REG_ITIME: itime <= (wdata_i[8:0] > TIME_MAX) ? TIME_MAX : wdata_i[8:0];
                REG_PMODE: pmode <= wdata_i[1:0];
                REG_SP_SRC: sp_src <= (wdata_i[1:0] == 2'h3) ? 2'h2 : wdata_i[1:0];
                REG_PRESET: preset <= (wdata_i[9:0] > PCT_FULL) ? PCT_FULL : wdata_i[9:0];
                REG_FB_SRC: fb_src <= (wdata_i[2:0] > 3'h5) ? 3'h5 : wdata_i[2:0];
                REG_WAKE: wake_lvl <= (wdata_i[9:0] > PCT_FULL) ? PCT_FULL : wdata_i[9:0];
                REG_SPEED_UNIT: speed_unit <= wdata_i[7:0];
                REG_RATED_I: rated_i <= (wdata_i[15:0] == 16'h0000) ? 16'h0001 :
                    wdata_i[15:0];
                default: ;
            endcase
        end
    end

    // Register reads, one cycle later
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                REG_DISP_FACTOR: rdata_o <= {17'h00000, disp_factor};
                REG_DISP_SRC: rdata_o <= {30'h0, disp_src};
                REG_PGAIN: rdata_o <= {23'h0, pgain};
                REG_ITIME: rdata_o <= {23'h0, itime};
                REG_PMODE: rdata_o <= {30'h0, pmode};
                REG_SP_SRC: rdata_o <= {30'h0, sp_src};
                REG_PRESET: rdata_o <= {22'h0, preset};
                REG_FB_SRC: rdata_o <= {29'h0, fb_src};
                REG_WAKE: rdata_o <= {22'h0, wake_lvl};
                REG_SPEED_UNIT: rdata_o <= {24'h0, speed_unit};
                REG_RATED_I: rdata_o <= {16'h0, rated_i};
                REG_AN1_STAT: rdata_o <= {22'h0, meas.an1};
                REG_AN2_STAT: rdata_o <= {22'h0, meas.an2};
                REG_FB_STAT: rdata_o <= {22'h0, fb};
                REG_OUT_STAT: rdata_o <= {22'h0, pi_out_o};
                REG_DISP_STAT: rdata_o <= display_o;
                REG_STBY_STAT: rdata_o <= {31'h0, stby_prev};
                default: rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Measurement synchroniser
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meas_q1 <= '0;
            meas <= '0;
        end else begin
            meas_q1 <= meas_i;
            meas <= meas_q1;
        end
    end

    // Fieldbus setpoint synchroniser
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bus_sp_q1 <= 10'h000;
            bus_sp <= 10'h000;
        end else begin
            bus_sp_q1 <= bus_setpoint_i;
            bus_sp <= bus_sp_q1;
        end
    end

    // Standby synchroniser
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stby_q1 <= 2'h0;
            stby <= 2'h0;
        end else begin
            stby_q1 <= {standby_en_i, standby_i};
            stby <= stby_q1;
        end
    end

    // Sample rate enable
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
        end else if (tick_cnt >= 32'(SAMPLE_CYCLES - 1)) begin
            tick_cnt <= 32'h0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
            tick <= 1'b0;
        end
    end

    // Setpoint selection
    always_comb begin
        case (sp_src)
            2'h0: next_sp = preset;
            2'h1: next_sp = meas.an1;
            default: next_sp = (bus_sp > PCT_FULL) ? PCT_FULL : bus_sp;
        endcase
    end

    // Feedback selection; widened so large currents do not wrap
    always_comb begin
        cur_pct = (26'(meas.motor_amps) * 26'd1000) / 26'(rated_i);
        case (fb_src)
            3'h0: next_fb = meas.an2;
            3'h1: next_fb = meas.an1;
            3'h2: next_fb = (cur_pct > 26'(PCT_FULL)) ? PCT_FULL : cur_pct[9:0];
            3'h3: next_fb = (meas.vbus > VBUS_FULL) ? PCT_FULL : meas.vbus;
            3'h4: next_fb = (meas.an1 > meas.an2) ? 10'(meas.an1 - meas.an2) : 10'h000;
            default: next_fb = (meas.an1 > meas.an2) ? meas.an1 : meas.an2;
        endcase
    end

    // PI arithmetic: output in tenths percent
    always_comb begin
        // gain on error, integral over time
        pterm = (32'(err) * $signed({23'h0, pgain})) / 32'sd10;
        next_integ = integ + 32'(err);
        if (itime == 9'h000) begin
            iterm = 32'sd0;
        end else begin
            iterm = next_integ / ($signed({23'h0, itime}) * 32'(TENTH_SAMPLES));
        end
        sum = pterm + iterm;
    end

    // Controller sequence
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= PID_IDLE;
        end else begin
            case (state)
                PID_IDLE: begin
                    if (tick) begin
                        state <= PID_FETCH;
                    end
                end
                PID_FETCH: begin
                    state <= PID_CALC;
                end
                PID_CALC: begin
                    if (wake_now) begin
                        state <= PID_WAKE;
                    end else begin
                        state <= PID_IDLE;
                    end
                end
                default: begin
                    state <= PID_IDLE;
                end
            endcase
        end
    end

    // Standby qualifier and wake condition
    assign in_stby = stby[1] & stby[0];
    assign wake_now = in_stby & (err > $signed({2'b00, wake_lvl}));

    // Sample capture and error sign
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fb <= 10'h000;
            sp <= 10'h000;
            err <= 12'sh000;
        end else if (state == PID_FETCH) begin
            fb <= next_fb;
            sp <= next_sp;
            if (!pmode[0]) begin
                err <= $signed({2'b00, next_sp}) - $signed({2'b00, next_fb});
            end else begin
                err <= $signed({2'b00, next_fb}) - $signed({2'b00, next_sp});
            end
        end
    end

    // PI output; comparisons stay signed so a negative sum floors at zero
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pi_out_o <= 10'h000;
        end else if (state == PID_WAKE && pmode[1]) begin
            pi_out_o <= PCT_FULL;
        end else if (state == PID_CALC && !in_stby) begin
            if (sum > $signed(32'(PCT_FULL))) begin
                pi_out_o <= PCT_FULL;
            end else if (sum < 32'sd0) begin
                pi_out_o <= 10'h000;
            end else begin
                pi_out_o <= sum[9:0];
            end
        end
    end

    // Integrator, frozen while the output is clamped so it cannot wind up
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            integ <= 32'sh0;
        end else if (state == PID_WAKE && pmode[1]) begin
            // Preload so regulation resumes from full output
            integ <= $signed(32'(PCT_FULL)) * 32'(TENTH_SAMPLES) * $signed({23'h0, itime});
        end else if (state == PID_CALC && !in_stby && sum >= 32'sd0 &&
            sum <= $signed(32'(PCT_FULL))) begin
            integ <= next_integ;
        end
    end

    // One-cycle wake pulse
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= (state == PID_CALC) && wake_now;
        end
    end

    // Standby status flag
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stby_prev <= 1'b0;
        end else if (state == PID_CALC) begin
            stby_prev <= in_stby;
        end else if (state == PID_WAKE) begin
            stby_prev <= 1'b0;
        end
    end

    // Display source selection
    always_comb begin
        case (disp_src)
            2'h0: disp_base = (speed_unit == 8'h00) ? meas.out_freq : meas.motor_rpm;
            2'h1: disp_base = meas.motor_amps;
            2'h2: disp_base = {6'h00, meas.an2};
            default: disp_base = {6'h00, fb};
        endcase
    end

    // Display product, factor in thousandths
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            display_o <= 32'h0000_0000;
        end else begin
            // multiply by factor
            // Operands widened first; the product needs 30 bits
            display_o <= (32'(disp_base) * 32'(disp_factor)) / 32'd1000;
        end
    end
endmodule

// file: bench/pid_ctrl_assertions.sv
// Port assertions for the PI controller
`timescale 1ns/10ps
module pid_ctrl_chk
    import pid_pkg::*;
#(
    parameter int SAMPLE_CYCLES = 10
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [9:0] pi_out_o,
    input wire logic wake_o,
    input wire logic [31:0] display_o
);
    logic [1:0] mode_q;
    logic [14:0] fac_q;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    // Shadow of mode and factor writes
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_q <= 2'h0;
            fac_q <= FACTOR_RST;
        end else if (wr_i) begin
            if (addr_i == REG_PMODE) begin
                mode_q <= wdata_i[1:0];
            end
            if (addr_i == REG_DISP_FACTOR) begin
                fac_q <= wdata_i[14:0];
            end
        end
    end
    property p_fac_max;
        rd_i && addr_i == REG_DISP_FACTOR |=> rdata_o <= {17'h0, FACTOR_MAX};
    endproperty
    a_fac_max: assert property (p_fac_max) else $error("factor above limit");
    property p_gain_max;
        rd_i && addr_i == REG_PGAIN |=> rdata_o <= {23'h0, GAIN_MAX};
    endproperty
    a_gain_max: assert property (p_gain_max) else $error("gain above limit");
    property p_time_max;
        rd_i && addr_i == REG_ITIME |=> rdata_o <= {23'h0, TIME_MAX};
    endproperty
    a_time_max: assert property (p_time_max) else $error("time above limit");
    property p_wake_max;
        rd_i && addr_i == REG_WAKE |=> rdata_o <= {22'h0, PCT_FULL};
    endproperty
    a_wake_max: assert property (p_wake_max) else $error("wake level above limit");
    property p_out_max;
        pi_out_o <= PCT_FULL;
    endproperty
    a_out_max: assert property (p_out_max) else $error("output above full scale");
    property p_wake_pulse;
        wake_o |=> !wake_o;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one");
    property p_wake_full;
        wake_o && mode_q[1] |=> pi_out_o == PCT_FULL;
    endproperty
    a_wake_full: assert property (p_wake_full) else $error("no full output on wake");
    property p_disp_zero;
        (fac_q == 15'h0)[*5] |-> display_o == 32'h0;
    endproperty
    a_disp_zero: assert property (p_disp_zero) else $error("display not zero");
    c_wake: cover property (wake_o && mode_q[1]);
    c_full: cover property (pi_out_o == PCT_FULL);
    c_wr_rd: cover property (wr_i ##2 rd_i);
endmodule
bind pid_ctrl pid_ctrl_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .pi_out_o(pi_out_o), .wake_o(wake_o), .display_o(display_o));

// file: bench/pid_sensors.sv
// Analog sensor and fieldbus master model for the controller
`timescale 1ns/10ps
module pid_sensors
    import pid_pkg::*;
(
    // Clock
    input wire logic clock_i,
    // Levels to present and fieldbus write
    input wire pid_pkg::pid_meas_s level_i,
    input wire logic bus_wr_i,
    input wire logic [9:0] bus_word_i,
    // Towards the controller
    output pid_pkg::pid_meas_s meas_o,
    output logic [9:0] bus_setpoint_o
);
    always @(posedge clock_i) begin
        meas_o <= level_i;
    end
    always @(posedge clock_i) begin
        if (bus_wr_i) begin
            bus_setpoint_o <= bus_word_i;
        end
    end
endmodule

// file: bench/tb_pi_loop_and_display_scaling.sv
// Self-checking bench for the PI controller and display scaling
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb_pi_loop_and_display_scaling;
    import pid_pkg::*;
    localparam int SC = 10;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic standby_en_i = 1'b0;
    logic standby_i = 1'b0;
    logic bus_wr = 1'b1;
    logic [9:0] bus_word = 10'h0;
    pid_meas_s level = '0;
    pid_meas_s meas;
    logic [9:0] bus_sp;
    logic [31:0] rdata_o;
    logic [9:0] pi_out_o;
    logic wake_o;
    logic [31:0] display_o;
    logic [15:0] lfsr = 16'h0045;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    pid_sensors fe (.clock_i(clock_i), .level_i(level), .bus_wr_i(bus_wr),
        .bus_word_i(bus_word), .meas_o(meas), .bus_setpoint_o(bus_sp));
    pid_ctrl #(.SAMPLE_CYCLES(SC)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .meas_i(meas), .bus_setpoint_i(bus_sp), .standby_en_i(standby_en_i),
        .standby_i(standby_i), .pi_out_o(pi_out_o), .wake_o(wake_o), .display_o(display_o));
    initial begin
        forever #50 clock_i = ~clock_i;
    end
    function automatic int rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return int'(lfsr) % 1001;
    endfunction
    function automatic int fb_of(int s, int a1, int a2, int vb);
        case (s)
            0: return a2;
            1: return a1;
            2: return 20 * 1000 / 40;
            3: return vb;
            4: return a1 > a2 ? a1 - a2 : 0;
            default: return a1 > a2 ? a1 : a2;
        endcase
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
        @(posedge clock_i);
    endtask
    // Several sample ticks plus pipeline latency
    task automatic settle();
        repeat (3 * SC + 8) @(posedge clock_i);
    endtask
    task automatic watch(output logic hit);
        hit = 1'b0;
        for (int i = 0; i < 4 * SC && hit !== 1'b1; i++) begin
            @(posedge clock_i);
            hit = wake_o;
        end
        @(posedge clock_i);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        int a1, a2, vb, p, bw, f, g, fb, sp, er, o1;
        int base[4];
        logic seen;
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        bus_wr <= 1'b0;
        @(posedge clock_i);
        rchk(REG_DISP_FACTOR, 32'h0);
        rchk(REG_PGAIN, 32'h0000000a);
        rchk(REG_ITIME, 32'h0000000a);
        rchk(REG_PRESET, 32'h0);
        rchk(REG_WAKE, 32'h00000032);
        // Integral alone, Ti 1.0 s: error 500 adds 5 per sample
        wr(REG_PGAIN, 0);
        wr(REG_PRESET, 500);
        settle();
        o1 = pi_out_o;
        settle();
        `CHK(pi_out_o > o1 + 10 && (pi_out_o - o1) % 5 == 0, 1'b1)
        wr(REG_DISP_FACTOR, 32'h00004e20);
        rchk(REG_DISP_FACTOR, 32'h00003e80);
        wr(REG_PGAIN, 32'h00000190);
        rchk(REG_PGAIN, 32'h0000012c);
        wr(REG_ITIME, 32'h0);
        wr(REG_RATED_I, 32'h00000028);
        wr(REG_DISP_SRC, 32'h3);
        for (int s = 0; s < 6; s++) begin
            a1 = rnd();
            a2 = rnd();
            vb = rnd();
            p = rnd();
            bw = rnd();
            f = rnd() * 16;
            g = (s == 5) ? 300 : 20;
            level <= '{an1: 10'(a1), an2: 10'(a2), motor_amps: 16'h0014, vbus: 10'(vb),
                out_freq: 16'h01f4, motor_rpm: 16'h05aa};
            bus_word <= 10'(bw);
            bus_wr <= 1'b1;
            wr(REG_PRESET, p);
            bus_wr <= 1'b0;
            wr(REG_PGAIN, g);
            wr(REG_PMODE, s % 2);
            wr(REG_SP_SRC, s % 3);
            wr(REG_FB_SRC, s);
            wr(REG_DISP_FACTOR, f);
            settle();
            fb = fb_of(s, a1, a2, vb);
            sp = (s % 3 == 0) ? p : (s % 3 == 1) ? a1 : bw;
            er = ((s % 2 == 0) ? sp - fb : fb - sp) * g / 10;
            rchk(REG_FB_STAT, fb);
            `CHK(pi_out_o, 10'(er < 0 ? 0 : er > 1000 ? 1000 : er))
            `CHK(display_o, 32'(fb * f / 1000))
        end
        base = '{500, 1450, 20, a2};
        for (int k = 0; k < 4; k++) begin
            wr(REG_DISP_SRC, k < 2 ? 0 : k - 1);
            wr(REG_SPEED_UNIT, k == 1);
            settle();
            `CHK(display_o, 32'(base[k] * f / 1000))
        end
        wr(REG_PMODE, 2);
        wr(REG_PGAIN, 20);
        wr(REG_SP_SRC, 0);
        wr(REG_FB_SRC, 0);
        level.an2 <= 10'h064;
        wr(REG_PRESET, 120);
        settle();
        standby_en_i <= 1'b1;
        standby_i <= 1'b1;
        watch(seen);
        `CHK(seen, 1'b0)
        wr(REG_PRESET, 800);
        watch(seen);
        `CHK(seen, 1'b1)
        `CHK(pi_out_o, PCT_FULL)
        // Mode 3: inverse regulation floors the output, then a wake forces full
        standby_i <= 1'b0;
        wr(REG_PMODE, 3);
        settle();
        `CHK(pi_out_o, 10'h000)
        standby_i <= 1'b1;
        wr(REG_PRESET, 0);
        watch(seen);
        `CHK(seen, 1'b1)
        `CHK(pi_out_o, PCT_FULL)
        summarize();
    end
endmodule
